/* File: core/asf_framer.v */
`timescale 1ns/100ps
`default_nettype none
`include "asf_consts.vh"
module asf_framer #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        sample_clock_pos,
  input  wire [15:0] sample_in,
  input  wire        sync_req_n,
  output reg         serial_line_out,
  output reg         dither_on,
  output reg  [1:0]  rate_range,
  output reg         shutdown
);
  reg  [`ASF_CTRL_W-1:0] ctrl_r;
  reg                    ovf_r;
  reg                    unf_r;
  reg                    sclk_d_r;
  reg  [15:0]            cap_r;
  reg                    cap_vld_r;
  reg  [`ASF_CNT_W-1:0]  bit_cnt_r;
  reg  [19:0]            shift_r;
  reg                    rd_r;
  reg  [2:0]             sreq_h_r;
  reg                    sync_r;
  reg  [14:0]            lfsr_r;
  reg  [15:0]            ramp_r;
  reg                    check_r;
  wire                   fifo_in_rdy;
  wire                   fifo_vld;
  wire [15:0]            fifo_data;
  wire [AW:0]            fifo_lvl;
  wire                   tick;
  wire                   pd;
  wire                   cap_edge;
  wire                   pop;
  wire                   sync_nxt;
  wire                   ovf_set;
  wire                   unf_set;
  wire                   wr_ovf_clr;
  wire                   wr_unf_clr;
  wire                   setup;
  wire                   hit_ctrl;
  wire                   hit_stat;
  wire [31:0]            stat_word;

  // 8b/10b encoder: returns {running disparity out, abcdei fghj}
  function [10:0] enc;
    input [7:0] d;
    input       k;
    input       rd;
    reg   [5:0] c6;
    reg   [3:0] c4;
    reg         rd6;
    reg         alt;
    integer     n;
    integer     m;
    integer     i;
    begin
      case (d[4:0])
        5'd0:  c6 = 6'b100111;
        5'd1:  c6 = 6'b011101;
        5'd2:  c6 = 6'b101101;
        5'd3:  c6 = 6'b110001;
        5'd4:  c6 = 6'b110101;
        5'd5:  c6 = 6'b101001;
        5'd6:  c6 = 6'b011001;
        5'd7:  c6 = 6'b111000;
        5'd8:  c6 = 6'b111001;
        5'd9:  c6 = 6'b100101;
        5'd10: c6 = 6'b010101;
        5'd11: c6 = 6'b110100;
        5'd12: c6 = 6'b001101;
        5'd13: c6 = 6'b101100;
        5'd14: c6 = 6'b011100;
        5'd15: c6 = 6'b010111;
        5'd16: c6 = 6'b011011;
        5'd17: c6 = 6'b100011;
        5'd18: c6 = 6'b010011;
        5'd19: c6 = 6'b110010;
        5'd20: c6 = 6'b001011;
        5'd21: c6 = 6'b101010;
        5'd22: c6 = 6'b011010;
        5'd23: c6 = 6'b111010;
        5'd24: c6 = 6'b110011;
        5'd25: c6 = 6'b100110;
        5'd26: c6 = 6'b010110;
        5'd27: c6 = 6'b110110;
        5'd28: c6 = k ? 6'b001111 : 6'b001110;
        5'd29: c6 = 6'b101110;
        5'd30: c6 = 6'b011110;
        default: c6 = 6'b101011;
      endcase
      n = 0;
      for (i = 0; i < 6; i = i + 1) begin
        n = n + c6[i];
      end
      if (rd && (n != 3 || d[4:0] == 5'd7)) begin
        c6 = ~c6;
      end
      rd6 = (n != 3) ? ~rd : rd;
      alt = k || (!rd6 && (d[4:0] == 5'd17 || d[4:0] == 5'd18 || d[4:0] == 5'd20))
               || (rd6 && (d[4:0] == 5'd11 || d[4:0] == 5'd13 || d[4:0] == 5'd14));
      case (d[7:5])
        3'd0: c4 = 4'b1011;
        3'd1: c4 = 4'b1001;
        3'd2: c4 = 4'b0101;
        3'd3: c4 = 4'b1100;
        3'd4: c4 = 4'b1101;
        3'd5: c4 = 4'b1010;
        3'd6: c4 = 4'b0110;
        default: c4 = alt ? 4'b0111 : 4'b1110;
      endcase
      m = 0;
      for (i = 0; i < 4; i = i + 1) begin
        m = m + c4[i];
      end
      if (rd6 && (m != 2 || d[7:5] == 3'd3)) begin
        c4 = ~c4;
      end else if (k && !rd6 && m == 2) begin
        c4 = ~c4;
      end
      enc = {((m != 2) ? ~rd6 : rd6), c6, c4};
    end
  endfunction

  // self-synchronous whitening, msb first: {new state, word}
  function [30:0] whiten;
    input [15:0] w;
    input [14:0] s;
    reg   [14:0] st;
    reg   [15:0] o;
    integer      i;
    begin
      st = s;
      o  = 16'h0000;
      for (i = 15; i >= 0; i = i - 1) begin
        o[i] = w[i] ^ st[13] ^ st[14];
        st   = {st[13:0], o[i]};
      end
      whiten = {st, o};
    end
  endfunction

  assign tick     = (bit_cnt_r == `ASF_CNT_LAST);
  assign pd       = ctrl_r[`ASF_CTRL_PD_HI] & ctrl_r[`ASF_CTRL_PD_LO];
  assign cap_edge = sample_clock_pos & ~sclk_d_r;
  assign pop      = tick & ~pd & ~sync_nxt & fifo_vld;
  // comma after request held two frames; data two frames after release
  assign sync_nxt = sync_r ? sreq_h_r[1] : (sreq_h_r[2] & sreq_h_r[1]);

  // sample capture stage; stalls while the fifo is full
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_r  <= 1'b0;
      cap_r     <= 16'h0000;
      cap_vld_r <= 1'b0;
    end else begin
      sclk_d_r <= sample_clock_pos;
      if (pd) begin
        cap_vld_r <= 1'b0;
      end else if (cap_edge && (!cap_vld_r || fifo_in_rdy)) begin
        cap_r     <= sample_in;
        cap_vld_r <= 1'b1;
      end else if (fifo_in_rdy) begin
        cap_vld_r <= 1'b0;
      end
    end
  end

  asf_fifo #(
    .WIDTH (16),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .flush     (pd),
    .in_valid  (cap_vld_r),
    .in_ready  (fifo_in_rdy),
    .in_data   (cap_r),
    .out_valid (fifo_vld),
    .out_ready (pop),
    .out_data  (fifo_data),
    .level     (fifo_lvl)
  );

  // frame content selection and encoding
  reg  [15:0] word;
  reg  [30:0] wh;
  reg  [7:0]  oct0;
  reg  [7:0]  oct1;
  reg         k0;
  reg         k1;
  reg  [10:0] cg0;
  reg  [10:0] cg1;
  always @* begin
    word = fifo_data;
    wh   = {lfsr_r, fifo_data};
    oct0 = `ASF_K28_5;
    oct1 = `ASF_K28_5;
    k0   = 1'b1;
    k1   = 1'b1;
    case (ctrl_r[`ASF_CTRL_PAT_HI:`ASF_CTRL_PAT_LO])
      `ASF_PAT_NORMAL: begin
        if (ctrl_r[`ASF_CTRL_FLIP]) begin
          word[15] = ~fifo_data[15];
        end
        if (ctrl_r[`ASF_CTRL_WHITEN]) begin
          wh   = whiten(word, lfsr_r);
          word = wh[15:0];
        end
      end
      `ASF_PAT_CHECK: word = check_r ? `ASF_CHECK_B : `ASF_CHECK_A;
      `ASF_PAT_RAMP:  word = ramp_r;
      `ASF_PAT_CONST: word = `ASF_CONST_WORD;
      default:        word = fifo_data;
    endcase
    if (!sync_nxt && fifo_vld) begin
      oct0 = word[15:8];
      oct1 = word[7:0];
      k0   = 1'b0;
      k1   = 1'b0;
      if (ctrl_r[`ASF_CTRL_MARKER] && word[7:0] == `ASF_MARK_MATCH) begin
        k1 = 1'b1;
      end
    end
    cg0 = enc(oct0, k0, rd_r);
    if (sync_nxt && ctrl_r[`ASF_CTRL_IDLE]) begin
      oct1 = cg0[10] ? `ASF_D16_2 : `ASF_D5_6;
      k1   = 1'b0;
    end
    cg1 = enc(oct1, k1, cg0[10]);
  end

  // line serializer, frame timing and pattern state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_r       <= {`ASF_CNT_W{1'b0}};
      shift_r         <= 20'h0_0000;
      rd_r            <= 1'b0;
      sreq_h_r        <= 3'b000;
      sync_r          <= 1'b0;
      lfsr_r          <= 15'h0000;
      ramp_r          <= 16'h0000;
      check_r         <= 1'b0;
      serial_line_out <= 1'b0;
    end else begin
      serial_line_out <= shift_r[19] & ~pd;
      if (tick) begin
        bit_cnt_r <= {`ASF_CNT_W{1'b0}};
        sreq_h_r  <= {sreq_h_r[1:0], ~sync_req_n};
        sync_r    <= sync_nxt;
        ramp_r    <= ramp_r + 16'h0001;
        check_r   <= ~check_r;
        if (pd) begin
          shift_r <= 20'h0_0000;
          rd_r    <= 1'b0;
        end else begin
          shift_r <= {cg0[9:0], cg1[9:0]};
          rd_r    <= cg1[10];
          if (pop && ctrl_r[`ASF_CTRL_WHITEN]) begin
            lfsr_r <= wh[30:16];
          end
        end
      end else begin
        bit_cnt_r <= bit_cnt_r + 1'b1;
        shift_r   <= {shift_r[18:0], 1'b0};
      end
    end
  end

  // status events; a set in the clearing cycle wins
  assign ovf_set    = cap_edge & cap_vld_r & ~fifo_in_rdy & ~pd;
  assign unf_set    = tick & ~pd & ~sync_nxt & ~fifo_vld;
  assign setup      = psel & ~penable;
  assign hit_ctrl   = (paddr == `ASF_ADDR_CTRL);
  assign hit_stat   = (paddr == `ASF_ADDR_STATUS);
  assign wr_ovf_clr = psel & penable & pwrite & hit_stat & pwdata[`ASF_STAT_OVF];
  assign wr_unf_clr = psel & penable & pwrite & hit_stat & pwdata[`ASF_STAT_UNF];
  assign stat_word  = {{(24-AW-1){1'b0}}, fifo_lvl, 4'h0, unf_r, ovf_r, pd, sync_r};

  // apb slave, zero wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= `ASF_CTRL_RESET;
      ovf_r      <= 1'b0;
      unf_r      <= 1'b0;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      dither_on  <= 1'b0;
      rate_range <= 2'b00;
      shutdown   <= 1'b0;
    end else begin
      pready     <= 1'b1;
      dither_on  <= ctrl_r[`ASF_CTRL_DITHER];
      rate_range <= ctrl_r[`ASF_CTRL_RATE_HI:`ASF_CTRL_RATE_LO];
      shutdown   <= pd;
      ovf_r      <= ovf_set | (ovf_r & ~wr_ovf_clr);
      unf_r      <= unf_set | (unf_r & ~wr_unf_clr);
      if (psel && penable && pwrite && hit_ctrl) begin
        ctrl_r <= pwdata[`ASF_CTRL_W-1:0];
      end
      if (setup) begin
        pslverr <= ~(hit_ctrl | hit_stat);
        if (hit_ctrl) begin
          prdata <= {{(32-`ASF_CTRL_W){1'b0}}, ctrl_r};
        end else if (hit_stat) begin
          prdata <= stat_word;
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: pkg/asf_consts.vh */
// Notes on behaviour
// - take a new sample each sample clock rise
// - dither control low off, high on
// - idle-set off: sync with repeated K28.5
// - idle-set on: K28.5 then D5.6/D16.2
// - two rate bits select sample-rate range
// - both power-down bits high shut down
// - sync request low at two frame ticks starts sync
// - frame marker sends a last group of FC as K28.7
// - pattern bits send test pattern instead
// - whitening uses 1+x^14+x^15 before encoding
// - top-bit flip inverts sample msb
// - commas start three frames after request
// - data resumes two frames after release
// - one sample is two octet code-groups
// - twenty line bits per sample period
`ifndef ASF_CONSTS_VH
`define ASF_CONSTS_VH

// apb register byte offsets
`define ASF_ADDR_CTRL     12'h000
`define ASF_ADDR_STATUS   12'h004
`define ASF_ADDR_W        12

// control register fields
`define ASF_CTRL_DITHER   0
`define ASF_CTRL_IDLE     1
`define ASF_CTRL_RATE_LO  2
`define ASF_CTRL_RATE_HI  3
`define ASF_CTRL_PD_LO    4
`define ASF_CTRL_PD_HI    5
`define ASF_CTRL_MARKER   6
`define ASF_CTRL_PAT_LO   7
`define ASF_CTRL_PAT_HI   8
`define ASF_CTRL_WHITEN   9
`define ASF_CTRL_FLIP     10
`define ASF_CTRL_W        11
`define ASF_CTRL_RESET    11'h000

// status register fields
`define ASF_STAT_SYNC     0
`define ASF_STAT_POWER_DOWN_PINS     1
`define ASF_STAT_OVF      2
`define ASF_STAT_UNF      3
`define ASF_STAT_LVL_LO   8

// line framing
`define ASF_FRAME_BITS    20
`define ASF_CNT_W         5
`define ASF_CNT_LAST      5'h13

// code-group octets
`define ASF_K28_5         8'hBC
`define ASF_K28_7         8'hFC
`define ASF_D5_6          8'hC5
`define ASF_D16_2         8'h50
`define ASF_MARK_MATCH    8'hFC

// test patterns
`define ASF_PAT_NORMAL    2'h0
`define ASF_PAT_CHECK     2'h1
`define ASF_PAT_RAMP      2'h2
`define ASF_PAT_CONST     2'h3
`define ASF_CHECK_A       16'h5555
`define ASF_CHECK_B       16'hAAAA
`define ASF_CONST_WORD    16'h0000

`endif

/* File: core/asf_fifo.v */
`timescale 1ns/100ps
`default_nettype none
module asf_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_r;
  reg [AW-1:0]    rd_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;

  // honest full and empty from the occupancy count
  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_r];
  assign level     = cnt_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage write
  always @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  // pointers and count
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/asf_framer_chk.sv */
`timescale 1ns/100ps
`default_nettype none
`include "asf_consts.vh"
module asf_framer_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_line_out,
  input wire logic        dither_on,
  input wire logic [1:0]  rate_range,
  input wire logic        shutdown
);
  logic [10:0] ctrl_r;
  logic [4:0]  off_r;
  wire         acc = psel && penable;
  wire         cadr = paddr == `ASF_ADDR_CTRL;
  wire         sadr = paddr == `ASF_ADDR_STATUS;

  // mirror of the control word and a count of cycles spent shut down
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 11'h000;
      off_r  <= 5'h00;
    end else begin
      if (acc && pwrite && cadr)
        ctrl_r <= pwdata[10:0];
      if (!shutdown)
        off_r <= 5'h00;
      else if (off_r != 5'h1F)
        off_r <= off_r + 5'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bus answers
  ready_acc_a: assert property (acc |-> pready)
    else $error("pready low in access");
  bad_addr_a: assert property (acc && !cadr && !sadr |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  good_addr_a: assert property (acc && (cadr || sadr) |-> !pslverr)
    else $error("mapped access refused");
  ctrl_read_a: assert property (acc && !pwrite && cadr |-> prdata == {21'h00_0000, ctrl_r})
    else $error("control readback wrong");
  // pin-level controls follow the control word
  dither_track_a: assert property ($stable(ctrl_r)[*3] |-> dither_on == ctrl_r[0])
    else $error("dither output wrong");
  rate_track_a: assert property ($stable(ctrl_r)[*3] |-> rate_range == ctrl_r[3:2])
    else $error("rate range wrong");
  power_down_pins_track_a: assert property ($stable(ctrl_r)[*3] |-> shutdown == &ctrl_r[5:4])
    else $error("shutdown wrong");
  line_quiet_a: assert property (off_r > 5'h17 |-> !serial_line_out)
    else $error("line active in shutdown");
endmodule

bind asf_framer asf_framer_chk asf_framer_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_line_out(serial_line_out),
  .dither_on(dither_on), .rate_range(rate_range), .shutdown(shutdown)
);
`default_nettype wire

/* File: verification/asf_rx_model.sv */
`timescale 1ns/100ps
`default_nettype none
module asf_rx_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        line,
  input  wire logic        sync_hold,
  output var  logic        sync_req_n,
  output var  logic [19:0] window_r
);
  // request held low for as long as asked; line shifted in, first bit ends on top
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_req_n <= 1'b1;
      window_r   <= 20'h0_0000;
    end else begin
      sync_req_n <= !sync_hold;
      // receiver picks its own latch edge; this one takes each bit on the rise
      window_r   <= {window_r[18:0], line};
    end
  end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "asf_consts.vh"
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sample_clock_pos;
  logic [15:0] sample_in;
  logic        sync_req_n;
  logic        serial_line_out;
  logic        dither_on;
  logic [1:0]  rate_range;
  logic        shutdown;
  logic        sync_hold;
  logic [19:0] rx_window;
  logic [3:0]  smp_cnt;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          n_tests;
  int          cyc;

  asf_framer #(.DEPTH(16), .AW(4)) asf_framer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_clock_pos(sample_clock_pos),
    .sample_in(sample_in), .sync_req_n(sync_req_n), .serial_line_out(serial_line_out),
    .dither_on(dither_on), .rate_range(rate_range), .shutdown(shutdown)
  );
  asf_rx_model asf_rx_model_inst (
    .clk(pclk), .rst_n(presetn), .line(serial_line_out),
    .sync_hold(sync_hold), .sync_req_n(sync_req_n), .window_r(rx_window)
  );

  // clock, sample clock at one period per frame, and hang guard
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    smp_cnt <= (smp_cnt == 4'h9) ? 4'h0 : smp_cnt + 4'h1;
    if (smp_cnt == 4'h9)
      sample_clock_pos <= !sample_clock_pos;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one bus transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_mode(input logic [10:0] ctrl, input logic [15:0] smp);
    apb(1'b1, `ASF_ADDR_CTRL, {21'h00_0000, ctrl});
    sample_in <= smp;
  endtask

  // wait for a whole frame on the line; lo and hi bound the wait
  task automatic wait_frame(input string what, input logic [19:0] exp, input int lo, input int hi);
    int i;
    i = 0;
    while (rx_window !== exp && i < hi) begin
      @(posedge pclk);
      i++;
    end
    check(what, 32'(i >= lo && i < hi), 32'h0000_0001);
  endtask

  task automatic t_regs();
    apb(1'b0, `ASF_ADDR_CTRL, 32'h0000_0000);
    check("ctrl reset", rd, 32'h0000_0000);
    apb(1'b1, `ASF_ADDR_CTRL, 32'h0000_001D);
    repeat (3) @(posedge pclk);
    check("dither", 32'(dither_on), 32'h0000_0001);
    check("rate", 32'(rate_range), 32'h0000_0003);
    check("one pd bit", 32'(shutdown), 32'h0000_0000);
    apb(1'b1, `ASF_ADDR_CTRL, 32'h0000_0008);
    repeat (3) @(posedge pclk);
    check("dither", 32'(dither_on), 32'h0000_0000);
    check("rate", 32'(rate_range), 32'h0000_0002);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check("unmapped err", 32'(err), 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
  endtask

  task automatic t_modes();
    set_mode(11'h400, 16'h0000);
    wait_frame("flip", 20'h9_CA74, 0, 1000);
    set_mode(11'h180, 16'hFFFF);
    wait_frame("pattern 3", 20'h9_D274, 0, 1000);
    set_mode(11'h080, 16'hFFFF);
    wait_frame("pattern 1", 20'hA_96A5, 0, 1000);
    set_mode(11'h040, 16'h00FC);
    wait_frame("marker", 20'h9_D0F8, 0, 1000);
  endtask

  task automatic t_sync(input logic [10:0] ctrl, input logic [19:0] exp);
    set_mode(ctrl, 16'h0000);
    wait_frame("data", 20'h9_D274, 0, 1000);
    sync_hold <= 1'b1;
    wait_frame("comma", exp, 70, 110);
    repeat (40) @(posedge pclk);
    sync_hold <= 1'b0;
    wait_frame("resume", 20'h9_D274, 50, 90);
  endtask

  task automatic t_shutdown();
    apb(1'b1, `ASF_ADDR_CTRL, 32'h0000_0030);
    repeat (30) @(posedge pclk);
    check("shutdown", 32'(shutdown), 32'h0000_0001);
    check("line", 32'(serial_line_out), 32'h0000_0000);
    apb(1'b1, `ASF_ADDR_STATUS, 32'h0000_000C);
    apb(1'b0, `ASF_ADDR_STATUS, 32'h0000_0000);
    check("status in shutdown", rd, 32'h0000_0002);
    apb(1'b1, `ASF_ADDR_CTRL, 32'h0000_0000);
    wait_frame("restart", 20'h9_D274, 0, 1000);
  endtask

  // first nonzero word through a zero whitening state: 8000 leaves as 8003
  task automatic t_white();
    set_mode(11'h200, 16'h8000);
    wait_frame("whitened", 20'h9_CB1B, 0, 1000);
  endtask

  // ramp words advance each frame, so frames twenty bits apart differ
  task automatic t_ramp();
    logic [19:0] w;
    set_mode(11'h100, 16'h0000);
    repeat (60) @(posedge pclk);
    w = rx_window;
    repeat (20) @(posedge pclk);
    check("ramp moves", 32'(w !== rx_window), 32'h0000_0001);
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // reset for three cycles, then the scenarios
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sample_clock_pos = 1'b0;
    sample_in = 16'h0000;
    sync_hold = 1'b0;
    smp_cnt = 4'h0;
    cyc = 0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_modes();
    t_sync(11'h000, 20'h3_EB05);
    t_sync(11'h002, 20'h3_EA45);
    t_shutdown();
    t_white();
    t_ramp();
    end_sim();
  end
endmodule
`default_nettype wire
